// >>> core/clkgen_pkg.sv
// Package with register map, field positions, reset values and mode codes for the serial clock generator
package clkgen_pkg;
    localparam logic [3:0] ADDR_DIVISOR_LOW = 4'h0;
    localparam logic [3:0] ADDR_DIVISOR_HIGH = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam int CTRL_SYNC_MODE_BIT = 0;
    localparam int CTRL_DOUBLE_SPEED_BIT = 1;
    localparam int CTRL_PIN_DIR_BIT = 2;
    localparam int CTRL_POLARITY_BIT = 3;
    localparam int CTRL_POWER_GATE_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h10;
    localparam logic [11:0] DIVISOR_RESET = 12'h000;
    localparam int DIVISOR_WIDTH = 12;
    localparam logic [3:0] FACTOR_NORMAL = 4'hF;
    localparam logic [3:0] FACTOR_DOUBLE = 4'h7;
    localparam logic [3:0] FACTOR_SYNC = 4'h1;
    localparam int SYSCLK_HZ = 25000000;
    typedef enum logic [1:0] {
        MODE_ASYNC_NORMAL = 2'h0,
        MODE_ASYNC_DOUBLE = 2'h1,
        MODE_SYNC_MASTER = 2'h3,
        MODE_SYNC_SLAVE = 2'h2
    } clk_mode_e;
endpackage

// >>> core/serial_clock_gen.sv
// Clock generator for a serial transceiver: baud counter, mode dividers, transfer clock pin, Wishbone registers
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module serial_clock_gen (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic xfer_clk_i,
    output logic xfer_clk_o,
    output logic xfer_clk_oe_n,
    output logic tx_clk_en,
    output logic rx_base_tick,
    output logic [3:0] rx_state_count_m1,
    output logic data_change_en,
    output logic data_sample_en
);
    logic [11:0] divisor_r, divisor_nxt;
    logic [4:0] ctrl_r, ctrl_nxt;
    logic [11:0] count_r, count_nxt;
    logic [3:0] prescale_r, prescale_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt, err_r, err_nxt;
    logic sync1_r, sync2_r, sync3_r;
    logic pin_r, pin_nxt, oe_n_r, oe_n_nxt;
    logic txclk_r, txclk_nxt, rxtick_r, rxtick_nxt;
    logic change_r, change_nxt, sample_r, sample_nxt;
    logic [3:0] states_r, states_nxt;
    logic bus_req, bus_wr, wr_low, wr_high, wr_ctrl, enabled, baud_tick;
    logic ext_rise, ext_fall, int_rise, int_fall;
    clkgen_pkg::clk_mode_e mode;

    function automatic logic [3:0] mode_factor_m1(input clkgen_pkg::clk_mode_e m);
        unique case (m)
            clkgen_pkg::MODE_ASYNC_NORMAL: mode_factor_m1 = clkgen_pkg::FACTOR_NORMAL;
            clkgen_pkg::MODE_ASYNC_DOUBLE: mode_factor_m1 = clkgen_pkg::FACTOR_DOUBLE;
            clkgen_pkg::MODE_SYNC_MASTER, clkgen_pkg::MODE_SYNC_SLAVE: mode_factor_m1 = clkgen_pkg::FACTOR_SYNC;
        endcase
    endfunction

    always_comb begin
        // Double speed is ignored once sync mode is chosen
        if (!ctrl_r[clkgen_pkg::CTRL_SYNC_MODE_BIT]) begin
            mode = ctrl_r[clkgen_pkg::CTRL_DOUBLE_SPEED_BIT] ? clkgen_pkg::MODE_ASYNC_DOUBLE
                                                             : clkgen_pkg::MODE_ASYNC_NORMAL;
        end else begin
            mode = ctrl_r[clkgen_pkg::CTRL_PIN_DIR_BIT] ? clkgen_pkg::MODE_SYNC_MASTER
                                                        : clkgen_pkg::MODE_SYNC_SLAVE;
        end
    end

    function automatic logic write_hit(input logic req, input logic [3:0] adr, input logic [3:0] target);
        write_hit = req && adr == target;
    endfunction

    assign enabled = !ctrl_r[clkgen_pkg::CTRL_POWER_GATE_BIT];
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    // Only the low byte lane carries writable register bits, so sel[0] alone gates a write
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign wr_low = write_hit(bus_wr, wb_adr_i, clkgen_pkg::ADDR_DIVISOR_LOW);
    assign wr_high = write_hit(bus_wr, wb_adr_i, clkgen_pkg::ADDR_DIVISOR_HIGH);
    assign wr_ctrl = write_hit(bus_wr, wb_adr_i, clkgen_pkg::ADDR_CONTROL);

    always_comb begin
        divisor_nxt = divisor_r;
        ctrl_nxt = ctrl_r;
        rdata_nxt = rdata_r;
        ack_nxt = 1'b0;
        err_nxt = 1'b0;
        if (wr_low) begin
            divisor_nxt[7:0] = wb_dat_i[7:0];
        end
        if (wr_high) begin
            divisor_nxt[11:8] = wb_dat_i[3:0];
        end
        if (wr_ctrl) begin
            ctrl_nxt = wb_dat_i[4:0];
        end
        if (bus_req) begin
            ack_nxt = 1'b1;
            rdata_nxt = 32'h0000_0000;
            unique case (wb_adr_i)
                clkgen_pkg::ADDR_DIVISOR_LOW: rdata_nxt[7:0] = divisor_r[7:0];
                clkgen_pkg::ADDR_DIVISOR_HIGH: rdata_nxt[3:0] = divisor_r[11:8];
                clkgen_pkg::ADDR_CONTROL: rdata_nxt[4:0] = ctrl_r;
                clkgen_pkg::ADDR_STATUS: rdata_nxt[15:0] = {mode, prescale_r, 10'(0)} | {4'h0, count_r};
                default: begin
                    ack_nxt = 1'b0;
                    err_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            divisor_r <= clkgen_pkg::DIVISOR_RESET;
            ctrl_r <= clkgen_pkg::CTRL_RESET;
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end else if (clk_en) begin
            divisor_r <= divisor_nxt;
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
        end
    end

    // Status word puts mode in 15:14 and the prescaler in 13:10, ORed over count bits 11:10, so read it mainly as a count
    // Baud down-counter; the zero count is the tick, so the period is divisor+1
    assign baud_tick = enabled && count_r == 12'h000;

    always_comb begin
        count_nxt = count_r;
        prescale_nxt = prescale_r;
        if (!enabled) begin
            count_nxt = divisor_r;
            prescale_nxt = 4'h0;
        end else if (wr_low || baud_tick) begin
            count_nxt = wr_low ? {divisor_r[11:8], wb_dat_i[7:0]} : divisor_r;
        end else begin
            count_nxt = count_r - 12'h001;
        end
        if (enabled && baud_tick && mode != clkgen_pkg::MODE_SYNC_SLAVE) begin
            prescale_nxt = (prescale_r >= mode_factor_m1(mode)) ? 4'h0 : prescale_r + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_r <= 12'h000;
            prescale_r <= 4'h0;
        end else if (clk_en) begin
            count_r <= count_nxt;
            prescale_r <= prescale_nxt;
        end
    end

    // Two-stage synchroniser, third stage only for edge detection
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else if (clk_en) begin
            sync1_r <= xfer_clk_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign ext_rise = sync2_r && !sync3_r;
    assign ext_fall = !sync2_r && sync3_r;
    // Master pin toggles at each tick, so its period is two ticks
    assign int_rise = baud_tick && !pin_r;
    assign int_fall = baud_tick && pin_r;

    always_comb begin
        pin_nxt = pin_r;
        oe_n_nxt = 1'b1;
        txclk_nxt = 1'b0;
        rxtick_nxt = 1'b0;
        change_nxt = 1'b0;
        sample_nxt = 1'b0;
        states_nxt = mode_factor_m1(mode);
        if (enabled) begin
            unique case (mode)
                clkgen_pkg::MODE_ASYNC_NORMAL, clkgen_pkg::MODE_ASYNC_DOUBLE: begin
                    pin_nxt = 1'b0;
                    rxtick_nxt = baud_tick;
                    txclk_nxt = baud_tick && prescale_r == mode_factor_m1(mode);
                end
                clkgen_pkg::MODE_SYNC_MASTER: begin
                    oe_n_nxt = 1'b0;
                    if (baud_tick) begin
                        pin_nxt = !pin_r;
                    end
                    rxtick_nxt = baud_tick;
                    txclk_nxt = baud_tick && prescale_r == mode_factor_m1(mode);
                    change_nxt = ctrl_r[clkgen_pkg::CTRL_POLARITY_BIT] ? int_fall : int_rise;
                    sample_nxt = ctrl_r[clkgen_pkg::CTRL_POLARITY_BIT] ? int_rise : int_fall;
                end
                clkgen_pkg::MODE_SYNC_SLAVE: begin
                    pin_nxt = 1'b0;
                    rxtick_nxt = ext_rise || ext_fall;
                    txclk_nxt = ctrl_r[clkgen_pkg::CTRL_POLARITY_BIT] ? ext_fall : ext_rise;
                    change_nxt = ctrl_r[clkgen_pkg::CTRL_POLARITY_BIT] ? ext_fall : ext_rise;
                    sample_nxt = ctrl_r[clkgen_pkg::CTRL_POLARITY_BIT] ? ext_rise : ext_fall;
                end
            endcase
        end else begin
            pin_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_r <= 1'b0;
            oe_n_r <= 1'b1;
            txclk_r <= 1'b0;
            rxtick_r <= 1'b0;
            change_r <= 1'b0;
            sample_r <= 1'b0;
            states_r <= clkgen_pkg::FACTOR_NORMAL;
        end else if (clk_en) begin
            pin_r <= pin_nxt;
            oe_n_r <= oe_n_nxt;
            txclk_r <= txclk_nxt;
            rxtick_r <= rxtick_nxt;
            change_r <= change_nxt;
            sample_r <= sample_nxt;
            states_r <= states_nxt;
        end
    end

    assign wb_dat_o = rdata_r;
    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign xfer_clk_o = pin_r;
    assign xfer_clk_oe_n = oe_n_r;
    assign tx_clk_en = txclk_r;
    assign rx_base_tick = rxtick_r;
    assign rx_state_count_m1 = states_r;
    assign data_change_en = change_r;
    assign data_sample_en = sample_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_RELOAD_ZERO: assert property (clk_en && baud_tick && !wr_low |=> count_r == $past(divisor_r))
        else $error("counter did not reload at zero");
    AST_RELOAD_LOW: assert property (clk_en && wr_low && enabled |=> count_r[7:0] == $past(wb_dat_i[7:0]))
        else $error("counter did not reload on low write");
    AST_TICK_PULSE: assert property (rx_base_tick && mode != clkgen_pkg::MODE_SYNC_SLAVE && divisor_r != 12'h000
                                     && clk_en |=> !rx_base_tick)
        else $error("tick wider than one cycle");
    AST_PIN_ASYNC: assert property (!ctrl_r[clkgen_pkg::CTRL_SYNC_MODE_BIT] && clk_en |=> xfer_clk_oe_n)
        else $error("pin driven in async mode");
    AST_PIN_MASTER: assert property (mode == clkgen_pkg::MODE_SYNC_MASTER && enabled && clk_en
                                     |=> !xfer_clk_oe_n)
        else $error("master not driving pin");
    AST_GATED: assert property (!enabled && clk_en |=> !tx_clk_en && !rx_base_tick)
        else $error("ticks while gated");
    AST_SLAVE_NO_BAUD: assert property (mode == clkgen_pkg::MODE_SYNC_SLAVE && clk_en && !ext_rise && !ext_fall
                                        |=> !rx_base_tick)
        else $error("baud tick used in slave mode");
    AST_SLAVE_SYNC: assert property (mode == clkgen_pkg::MODE_SYNC_SLAVE && enabled && clk_en && ext_rise
                                     |=> rx_base_tick)
        else $error("slave edge not passed on");
    AST_DOUBLE_SYNC: assert property (ctrl_r[clkgen_pkg::CTRL_SYNC_MODE_BIT] && clk_en
                                      |=> rx_state_count_m1 == clkgen_pkg::FACTOR_SYNC)
        else $error("double speed acted in sync mode");
    AST_TX_DIV: assert property ($rose(tx_clk_en) && $past(mode) == clkgen_pkg::MODE_ASYNC_NORMAL
                                 |-> $past(prescale_r) == clkgen_pkg::FACTOR_NORMAL)
        else $error("transmit divide wrong");

    // Checker helpers: last value loaded into the counter and cycles since that load
    logic [11:0] load_r, load_nxt, gap_r, gap_nxt;

    always_comb begin
        load_nxt = load_r;
        gap_nxt = gap_r + 12'h001;
        if (!enabled || wr_low || baud_tick) begin
            load_nxt = count_nxt;
            gap_nxt = 12'h000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            load_r <= 12'h000;
            gap_r <= 12'h000;
        end else if (clk_en) begin
            load_r <= load_nxt;
            gap_r <= gap_nxt;
        end
    end

    AST_TICK_PERIOD: assert property (baud_tick && clk_en |-> gap_r == load_r)
        else $error("baud tick period wrong");
    AST_NORMAL_STATES: assert property (mode == clkgen_pkg::MODE_ASYNC_NORMAL && clk_en
                                        |=> rx_state_count_m1 == clkgen_pkg::FACTOR_NORMAL)
        else $error("receiver state count wrong in normal mode");
    AST_DOUBLE_STATES: assert property (mode == clkgen_pkg::MODE_ASYNC_DOUBLE && clk_en
                                        |=> rx_state_count_m1 == clkgen_pkg::FACTOR_DOUBLE)
        else $error("receiver state count wrong in double mode");
    AST_PIN_LOW_ASYNC: assert property (!ctrl_r[clkgen_pkg::CTRL_SYNC_MODE_BIT] && clk_en
                                        |=> !xfer_clk_o)
        else $error("pin level moved in async mode");
    AST_MASTER_TOGGLE: assert property (mode == clkgen_pkg::MODE_SYNC_MASTER && enabled
                                        && baud_tick && clk_en |=> xfer_clk_o != $past(xfer_clk_o))
        else $error("master pin did not toggle on tick");
    AST_SLAVE_INPUT: assert property (mode == clkgen_pkg::MODE_SYNC_SLAVE && clk_en |=> xfer_clk_oe_n)
        else $error("slave drove the pin");
    AST_TX_PULSE: assert property (tx_clk_en && clk_en && mode != clkgen_pkg::MODE_SYNC_SLAVE
                                   && $past(mode) == mode |=> !tx_clk_en)
        else $error("transmit enable wider than one cycle");
    AST_EDGE_APART: assert property (!(data_change_en && data_sample_en))
        else $error("change and sample on one edge");
    AST_SLAVE_SAMPLE: assert property (mode == clkgen_pkg::MODE_SYNC_SLAVE && enabled && clk_en
                                       && ext_fall && !ctrl_r[clkgen_pkg::CTRL_POLARITY_BIT] |=> data_sample_en)
        else $error("slave sample edge missed");
    AST_FROZEN: assert property (!clk_en |=> $stable(count_r) && $stable(prescale_r) && $stable(ctrl_r))
        else $error("state moved while clock enable low");
    AST_HIGH_WRITE: assert property (wr_high && clk_en |=> divisor_r[11:8] == $past(wb_dat_i[3:0]))
        else $error("divisor high write lost");

    COV_NORMAL: cover property (tx_clk_en && mode == clkgen_pkg::MODE_ASYNC_NORMAL);
    COV_DOUBLE: cover property (tx_clk_en && mode == clkgen_pkg::MODE_ASYNC_DOUBLE);
    COV_MASTER: cover property (data_sample_en && mode == clkgen_pkg::MODE_SYNC_MASTER);
    COV_SLAVE: cover property (data_change_en && mode == clkgen_pkg::MODE_SYNC_SLAVE);
    COV_FROZEN: cover property (!clk_en && rx_base_tick);
endmodule
`default_nettype wire

// >>> verification/remote_peer.sv
// Model of the far transceiver: supplies the transfer clock in slave mode
`timescale 1ns/1ps
`default_nettype none
module remote_peer (
    input wire logic sys_clk,
    input wire logic en,
    input wire logic run,
    input wire logic [7:0] half,
    output logic clk_out,
    output logic drive_en
);
    logic [7:0] cnt_r;
    initial begin
        clk_out = 1'b0;
        drive_en = 1'b0;
        cnt_r = 8'h00;
    end
    // Clock stands still between frames; half of three or more keeps it under a quarter of sys_clk
    always @(posedge sys_clk) begin
        drive_en <= en;
        if (!run) begin
            cnt_r <= 8'h00;
        end else if (cnt_r + 8'h01 >= half) begin
            cnt_r <= 8'h00;
            clk_out <= ~clk_out;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_serial_clock_gen.sv
// Self-checking bench for the serial clock generator
`timescale 1ns/1ps
`default_nettype none
module tb_serial_clock_gen;
    logic sys_clk, rst, clk_en, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, er;
    logic [3:0] wb_adr_i, wb_sel_i, rx_state_count_m1;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic xfer_clk_o, xfer_clk_oe_n, tx_clk_en, rx_base_tick, data_change_en, data_sample_en;
    logic p_en, p_run, p_clk, p_drv, float_r, pin;
    logic [7:0] p_half;
    int n_errors, comparisons;
    // An undriven pin wanders so a design that listens to it when it should not is caught
    assign pin = !xfer_clk_oe_n ? xfer_clk_o : (p_drv ? p_clk : float_r);
    serial_clock_gen i_serial_clock_gen (.sys_clk, .rst, .clk_en, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
        .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .xfer_clk_i(pin), .xfer_clk_o, .xfer_clk_oe_n,
        .tx_clk_en, .rx_base_tick, .rx_state_count_m1, .data_change_en, .data_sample_en);
    remote_peer i_remote_peer (.sys_clk, .en(p_en), .run(p_run), .half(p_half), .clk_out(p_clk), .drive_en(p_drv));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial float_r = 1'b0;
    always @(posedge sys_clk) float_r <= ~float_r;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
        int k;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_we_i <= w;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
        if (k >= 20) begin
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic cfg(input logic [31:0] ctl, input logic [31:0] hi, input logic [31:0] lo);
        bus(clkgen_pkg::ADDR_DIVISOR_HIGH, hi, 1'b1);
        bus(clkgen_pkg::ADDR_DIVISOR_LOW, lo, 1'b1);
        bus(clkgen_pkg::ADDR_CONTROL, ctl, 1'b1);
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return rx_base_tick;
            1: return tx_clk_en;
            2: return xfer_clk_o;
            3: return data_change_en;
            default: return data_sample_en;
        endcase
    endfunction
    // Cycles between two rising edges of the picked signal
    task automatic gap(input int s, input int exp);
        int k, first;
        logic pv;
        first = -1;
        pv = 1'b1;
        for (k = 0; k < 5000; k++) begin
            @(posedge sys_clk);
            if (pick(s) && !pv) begin
                if (first >= 0) break;
                first = k;
            end
            pv = pick(s);
        end
        check(k - first, exp);
        if (k == 5000) begin
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic count(input int s, input int n, output int c);
        logic pv;
        pv = pick(s);
        c = 0;
        repeat (n) begin
            @(posedge sys_clk);
            if (pick(s) && !pv) c++;
            pv = pick(s);
        end
    endtask
    task automatic burst(input int n);
        p_run <= 1'b1;
        repeat (n) @(posedge sys_clk);
        p_run <= 1'b0;
    endtask
    task automatic s_reset;
        int c;
        check(xfer_clk_oe_n, 1'b1);
        check(rx_state_count_m1, 4'hF);
        bus(clkgen_pkg::ADDR_CONTROL, 32'h0, 1'b0);
        check(rd, 32'h10);
        count(0, 40, c);
        check(c, 0);
    endtask
    task automatic s_bus;
        bus(4'h2, 32'h0, 1'b0);
        check(er, 1'b1);
        bus(clkgen_pkg::ADDR_DIVISOR_HIGH, 32'hFF, 1'b1);
        bus(clkgen_pkg::ADDR_DIVISOR_HIGH, 32'h0, 1'b0);
        check(rd, 32'hF);
        wb_sel_i <= 4'h0;
        bus(clkgen_pkg::ADDR_DIVISOR_LOW, 32'h5A, 1'b1);
        wb_sel_i <= 4'hF;
        bus(clkgen_pkg::ADDR_DIVISOR_LOW, 32'h0, 1'b0);
        check(rd, 32'h0);
    endtask
    // Clock enable low must stop the tick; one settling edge before counting avoids a pulse in flight
    task automatic s_freeze;
        int c;
        cfg(32'h0, 32'h0, 32'h3);
        clk_en <= 1'b0;
        @(posedge sys_clk);
        count(0, 20, c);
        check(c, 0);
        clk_en <= 1'b1;
        count(0, 20, c);
        check(c == 4 || c == 5, 1'b1);
    endtask
    task automatic s_modes;
        logic [31:0] ctl [4] = '{32'h0, 32'h2, 32'h5, 32'h7};
        int tx [4] = '{64, 32, 8, 8};
        logic [3:0] st [4] = '{4'hF, 4'h7, 4'h1, 4'h1};
        int i, c;
        for (i = 0; i < 4; i++) begin
            cfg(ctl[i], 32'h0, 32'h3);
            gap(0, 4);
            gap(1, tx[i]);
            check(rx_state_count_m1, st[i]);
            check(xfer_clk_oe_n, i < 2);
            if (i >= 2) gap(2, 8);
            else check(xfer_clk_o, 1'b0);
        end
        cfg(32'h0, 32'h1, 32'h0);
        gap(0, 257);
        // A low write must restart the count, not wait out the old divisor
        cfg(32'h0, 32'h0, 32'hC8);
        gap(0, 201);
        bus(clkgen_pkg::ADDR_DIVISOR_LOW, 32'h3, 1'b1);
        count(0, 8, c);
        check(c > 0, 1'b1);
    endtask
    task automatic s_slave;
        int c, pol;
        p_en <= 1'b1;
        p_half <= 8'h04;
        for (pol = 0; pol < 2; pol++) begin
            cfg(32'h1 | (pol << 3), 32'h0, 32'h3);
            check(xfer_clk_oe_n, 1'b1);
            check(rx_state_count_m1, 4'h1);
            burst(4);
            count(3 + pol, 10, c);
            check(c, 1);
            burst(4);
            count(4 - pol, 10, c);
            check(c, 1);
        end
        p_half <= 8'h03;
        fork
            burst(24);
            count(0, 34, c);
        join
        check(c, 8);
        fork
            burst(24);
            count(1, 34, c);
        join
        check(c, 4);
        count(0, 40, c);
        check(c, 0);
        p_en <= 1'b0;
    endtask
    initial begin
        n_errors = 0;
        comparisons = 0;
        rst = 1'b1;
        clk_en = 1'b1;
        wb_adr_i = 4'h0;
        wb_dat_i = 32'h0;
        wb_we_i = 1'b0;
        wb_sel_i = 4'hF;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        p_en = 1'b0;
        p_run = 1'b0;
        p_half = 8'h04;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        s_reset();
        s_bus();
        s_modes();
        s_freeze();
        s_slave();
        end_of_test();
    end
endmodule
`default_nettype wire
